//--- src/pss_pkg.sv
// Constants and types shared by the serial-load synthesizer front end.
package pss_pkg;
    localparam int unsigned WORD_W      = 16;
    localparam int unsigned CTRL_BIT    = 0;
    localparam int unsigned REF_CNT_W   = 13;
    localparam int unsigned REF_CNT_LSB = 1;
    localparam int unsigned LSEL_LSB    = 14;
    localparam int unsigned A_CNT_W     = 5;
    localparam int unsigned A_CNT_LSB   = 1;
    localparam int unsigned B_CNT_W     = 10;
    localparam int unsigned B_CNT_LSB   = 6;
    localparam int unsigned PRE_W       = 6;
    localparam logic [5:0]  PRE_LOW     = 6'h20;
    localparam logic [5:0]  PRE_HIGH    = 6'h21;
    localparam logic [15:0] WORD_RESET  = 16'h0000;
    localparam logic [1:0]  LSEL_REF    = 2'h0;
    localparam logic [1:0]  LSEL_FB     = 2'h1;
    localparam logic [1:0]  LSEL_DLOCK  = 2'h2;
    localparam logic [1:0]  LSEL_ALOCK  = 2'h3;
    localparam int unsigned ERR_W       = 8;
    localparam logic [7:0]  LOCK_WIN    = 8'h04;
    localparam logic [2:0]  LOCK_GOOD   = 3'h4;
    localparam int unsigned SYNC_N      = 6;
    localparam int unsigned IN_SCLK     = 0;
    localparam int unsigned IN_SDATA    = 1;
    localparam int unsigned IN_STROBE   = 2;
    localparam int unsigned IN_REFOSC   = 3;
    localparam int unsigned IN_RF       = 4;
    localparam int unsigned IN_PWR      = 5;
    typedef enum logic [1:0] {PD_IDLE, PD_UP, PD_DOWN} pss_pd_state_t;
endpackage

//--- src/pss_sync3.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
module pss_sync3 (
    input  wire logic ref_clk_i,
    input  wire logic nrst_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o
);
    logic s1;
    logic s2;
    logic s3;
    logic next_level;
    logic next_rise;

    always_comb begin
        next_level = level_o;
        next_rise  = 1'b0;
        if (s2 == s3) begin
            next_level = s3;
            next_rise  = s3 & ~level_o;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            s1      <= 1'b0;
            s2      <= 1'b0;
            s3      <= 1'b0;
            level_o <= 1'b0;
            rise_o  <= 1'b0;
        end else begin
            s1      <= pin_i;
            s2      <= s1;
            s3      <= s2;
            level_o <= next_level;
            rise_o  <= next_rise;
        end
    end
endmodule

//--- src/pss_synth_front.sv
// Serial programming, dividers, phase detector and lock indicator of the synthesizer.
// Contract
// R1: Sample data on each serial clock rise.
// R2: Word arrives MSB first; LSB selects destination.
// R3: Strobe rise copies word into chosen register.
// R4: Power enable low: asynchronous power-down, pump released. Only the pump clears at once; the rest follows the synchronised enable.
// R5: Lock output selects one of four sources.
// R6: Dual modulus prescaler divides RF by 32/33.
module pss_synth_front (
    input  wire logic ref_clk_i,
    input  wire logic nrst_i,
    input  wire logic serial_clk_i,
    input  wire logic serial_data_i,
    input  wire logic word_latch_strobe_i,
    input  wire logic pwr_enable_i,
    input  wire logic ref_osc_input_i,
    input  wire logic rf_prescaler_input_i,
    output logic      pump_output_o,
    output logic      pump_output_oe_n_o,
    output logic      lock_indicator_out_o,
    output logic      lock_indicator_out_oe_n_o
);
    logic [pss_pkg::SYNC_N-1:0] pin_raw;
    logic [pss_pkg::SYNC_N-1:0] pin_lvl;
    logic [pss_pkg::SYNC_N-1:0] pin_rise;

    assign pin_raw[pss_pkg::IN_SCLK]   = serial_clk_i;
    assign pin_raw[pss_pkg::IN_SDATA]  = serial_data_i;
    assign pin_raw[pss_pkg::IN_STROBE] = word_latch_strobe_i;
    assign pin_raw[pss_pkg::IN_REFOSC] = ref_osc_input_i;
    assign pin_raw[pss_pkg::IN_RF]     = rf_prescaler_input_i;
    assign pin_raw[pss_pkg::IN_PWR]    = pwr_enable_i;

    for (genvar g = 0; g < pss_pkg::SYNC_N; g++) begin : g_sync
        pss_sync3 u_sync (
            .ref_clk_i (ref_clk_i),
            .nrst_i    (nrst_i),
            .pin_i     (pin_raw[g]),
            .level_o   (pin_lvl[g]),
            .rise_o    (pin_rise[g])
        );
    end

    // Synchronised copy of the enable gates counting; the raw pin clears the pump at once.
    logic powered;
    assign powered = pin_lvl[pss_pkg::IN_PWR];

    // Serial shift and load.
    logic [pss_pkg::WORD_W-1:0] shift_word;
    logic [pss_pkg::WORD_W-1:0] fb_word;
    logic [pss_pkg::WORD_W-1:0] ref_word;
    logic [pss_pkg::WORD_W-1:0] next_shift_word;
    logic [pss_pkg::WORD_W-1:0] next_fb_word;
    logic [pss_pkg::WORD_W-1:0] next_ref_word;

    always_comb begin
        next_shift_word = shift_word;
        next_fb_word    = fb_word;
        next_ref_word   = ref_word;
        if (pin_rise[pss_pkg::IN_SCLK]) begin
            next_shift_word = {shift_word[pss_pkg::WORD_W-2:0],
                               pin_lvl[pss_pkg::IN_SDATA]}; // R1 R2
        end
        if (pin_rise[pss_pkg::IN_STROBE]) begin
            if (shift_word[pss_pkg::CTRL_BIT]) begin // R2
                next_fb_word = shift_word; // R3
            end else begin
                next_ref_word = shift_word; // R3
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            shift_word <= pss_pkg::WORD_RESET;
            fb_word    <= pss_pkg::WORD_RESET;
            ref_word   <= pss_pkg::WORD_RESET;
        end else begin
            shift_word <= next_shift_word;
            fb_word    <= next_fb_word;
            ref_word   <= next_ref_word;
        end
    end

    logic [pss_pkg::REF_CNT_W-1:0] ref_count;
    logic [pss_pkg::A_CNT_W-1:0]   a_count;
    logic [pss_pkg::B_CNT_W-1:0]   b_count;
    logic [1:0]                    lock_sel;
    assign ref_count = ref_word[pss_pkg::REF_CNT_LSB +: pss_pkg::REF_CNT_W];
    assign lock_sel  = ref_word[pss_pkg::LSEL_LSB +: 2];
    assign a_count   = fb_word[pss_pkg::A_CNT_LSB +: pss_pkg::A_CNT_W];
    assign b_count   = fb_word[pss_pkg::B_CNT_LSB +: pss_pkg::B_CNT_W];

    // Reference and feedback dividers. Divide ratio is P*B+A with B at least A.
    logic [pss_pkg::REF_CNT_W-1:0] ref_left;
    logic [pss_pkg::PRE_W-1:0]     pre_cnt;
    logic [pss_pkg::A_CNT_W-1:0]   a_left;
    logic [pss_pkg::B_CNT_W-1:0]   b_left;
    logic                          ref_pulse;
    logic                          fb_pulse;
    logic [pss_pkg::REF_CNT_W-1:0] next_ref_left;
    logic [pss_pkg::PRE_W-1:0]     next_pre_cnt;
    logic [pss_pkg::A_CNT_W-1:0]   next_a_left;
    logic [pss_pkg::B_CNT_W-1:0]   next_b_left;
    logic                          next_ref_pulse;
    logic                          next_fb_pulse;
    logic [pss_pkg::PRE_W-1:0]     modulus;

    always_comb begin
        next_ref_left  = ref_left;
        next_pre_cnt   = pre_cnt;
        next_a_left    = a_left;
        next_b_left    = b_left;
        next_ref_pulse = 1'b0;
        next_fb_pulse  = 1'b0;
        modulus = (a_left != '0) ? pss_pkg::PRE_HIGH : pss_pkg::PRE_LOW; // R6
        if (powered && pin_rise[pss_pkg::IN_REFOSC]) begin
            if (ref_left <= 1) begin
                next_ref_left  = ref_count;
                next_ref_pulse = 1'b1;
            end else begin
                next_ref_left = ref_left - 1'b1;
            end
        end
        if (powered && pin_rise[pss_pkg::IN_RF]) begin
            if (pre_cnt >= modulus - 1'b1) begin // R6
                next_pre_cnt = '0;
                if (a_left != '0) begin
                    next_a_left = a_left - 1'b1;
                end
                if (b_left <= 1) begin
                    next_b_left   = b_count;
                    next_a_left   = a_count;
                    next_fb_pulse = 1'b1;
                end else begin
                    next_b_left = b_left - 1'b1;
                end
            end else begin
                next_pre_cnt = pre_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            ref_left  <= '0;
            pre_cnt   <= '0;
            a_left    <= '0;
            b_left    <= '0;
            ref_pulse <= 1'b0;
            fb_pulse  <= 1'b0;
        end else begin
            ref_left  <= next_ref_left;
            pre_cnt   <= next_pre_cnt;
            a_left    <= next_a_left;
            b_left    <= next_b_left;
            ref_pulse <= next_ref_pulse;
            fb_pulse  <= next_fb_pulse;
        end
    end

    // Phase detector and digital lock judgement.
    pss_pkg::pss_pd_state_t  pd_state;
    pss_pkg::pss_pd_state_t  next_pd_state;
    logic [pss_pkg::ERR_W-1:0] err_cnt;
    logic [pss_pkg::ERR_W-1:0] next_err_cnt;
    logic [2:0]                good_cnt;
    logic [2:0]                next_good_cnt;
    logic                      err_end;

    always_comb begin
        next_pd_state = pd_state;
        next_err_cnt  = err_cnt;
        next_good_cnt = good_cnt;
        err_end       = 1'b0;
        case (pd_state)
            pss_pkg::PD_IDLE: begin
                next_err_cnt = '0;
                if (ref_pulse && fb_pulse) begin
                    err_end = 1'b1;
                end else if (ref_pulse) begin
                    next_pd_state = pss_pkg::PD_UP;
                end else if (fb_pulse) begin
                    next_pd_state = pss_pkg::PD_DOWN;
                end
            end
            pss_pkg::PD_UP, pss_pkg::PD_DOWN: begin
                if (err_cnt != '1) begin
                    next_err_cnt = err_cnt + 1'b1;
                end
                if ((pd_state == pss_pkg::PD_UP && fb_pulse)
                    || (pd_state == pss_pkg::PD_DOWN && ref_pulse)) begin
                    next_pd_state = pss_pkg::PD_IDLE;
                    err_end       = 1'b1;
                end
            end
            default: begin
                next_pd_state = pss_pkg::PD_IDLE;
            end
        endcase
        if (err_end) begin
            if (err_cnt > pss_pkg::LOCK_WIN) begin
                next_good_cnt = '0;
            end else if (good_cnt != pss_pkg::LOCK_GOOD) begin
                next_good_cnt = good_cnt + 1'b1;
            end
        end
        if (!powered) begin
            next_pd_state = pss_pkg::PD_IDLE;
            next_good_cnt = '0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            pd_state <= pss_pkg::PD_IDLE;
            err_cnt  <= '0;
            good_cnt <= '0;
        end else begin
            pd_state <= next_pd_state;
            err_cnt  <= next_err_cnt;
            good_cnt <= next_good_cnt;
        end
    end

    // Lock indicator source select; open-drain only in analog mode.
    logic next_lock_out;
    logic next_lock_oe_n;

    always_comb begin
        next_lock_out  = 1'b0;
        next_lock_oe_n = 1'b0;
        case (lock_sel) // R5
            pss_pkg::LSEL_REF:   next_lock_out = ref_pulse;
            pss_pkg::LSEL_FB:    next_lock_out = fb_pulse;
            pss_pkg::LSEL_DLOCK: next_lock_out = (good_cnt == pss_pkg::LOCK_GOOD);
            pss_pkg::LSEL_ALOCK: next_lock_oe_n = (pd_state == pss_pkg::PD_IDLE);
            default:             next_lock_out = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            lock_indicator_out_o      <= 1'b0;
            lock_indicator_out_oe_n_o <= 1'b0;
        end else begin
            lock_indicator_out_o      <= next_lock_out;
            lock_indicator_out_oe_n_o <= next_lock_oe_n;
        end
    end

    // Pump drive. The raw enable clears these flops with no clock, so the pump
    // releases even when the reference clock has stopped.
    logic next_pump;
    logic next_pump_oe_n;

    always_comb begin
        next_pump      = (next_pd_state == pss_pkg::PD_UP);
        next_pump_oe_n = (next_pd_state == pss_pkg::PD_IDLE) || !powered;
    end

    always_ff @(posedge ref_clk_i or negedge pwr_enable_i) begin
        if (!pwr_enable_i) begin
            pump_output_o      <= 1'b0; // R4
            pump_output_oe_n_o <= 1'b1; // R4
        end else if (!nrst_i) begin
            pump_output_o      <= 1'b0;
            pump_output_oe_n_o <= 1'b1;
        end else begin
            pump_output_o      <= next_pump;
            pump_output_oe_n_o <= next_pump_oe_n;
        end
    end
endmodule

//--- tb/pss_host_model.sv
// Behavioural host that shifts programming words over the three-wire link.
module pss_host_model (
    output logic serial_clk_o,
    output logic serial_data_o,
    output logic word_latch_strobe_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        serial_clk_o = 1'b0;
        serial_data_o = 1'b0;
        word_latch_strobe_o = 1'b0;
    end
    // The link clock idles low between frames, 80 ns period within a frame.
    task automatic send_word(input logic [15:0] word);
        for (int i = 15; i >= 0; i--) begin
            serial_data_o = word[i];
            #40;
            serial_clk_o = 1'b1;
            #40;
            serial_clk_o = 1'b0;
        end
        // The data line has no pull, so a stale bit must never look valid.
        serial_data_o = ~word[0];
        #40;
        word_latch_strobe_o = 1'b1;
        #40;
        word_latch_strobe_o = 1'b0;
        #40;
    endtask
endmodule

//--- tb/pss_synth_front_sva.sv
// Pin-level checks on the synthesizer front end.
module pss_synth_front_sva (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic word_latch_strobe_i,
    input wire logic pwr_enable_i,
    input wire logic ref_osc_input_i,
    input wire logic rf_prescaler_input_i,
    input wire logic pump_output_o,
    input wire logic pump_output_oe_n_o,
    input wire logic lock_indicator_out_o,
    input wire logic lock_indicator_out_oe_n_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    logic [3:0] prev_in;
    logic [3:0] quiet;
    logic [3:0] next_prev_in;
    logic [3:0] next_quiet;
    // Cycles since any pin that can cause output activity last moved.
    always_comb begin
        next_prev_in = {ref_osc_input_i, rf_prescaler_input_i, word_latch_strobe_i, pwr_enable_i};
        next_quiet = quiet;
        if (next_prev_in != prev_in) begin
            next_quiet = 4'h0;
        end else if (quiet != 4'hF) begin
            next_quiet = quiet + 4'h1;
        end
        if (!nrst_i) begin
            next_quiet = 4'h0;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        prev_in <= next_prev_in;
        quiet <= next_quiet;
    end
    sequence pump_off_s;
        pump_output_oe_n_o && !pump_output_o;
    endsequence
    sequence recent_cause_s;
        quiet <= 4'hA;
    endsequence
    pd_tristate_a: assert property (!pwr_enable_i |-> pump_off_s)
        else $error("pump driven while powered down");
    pd_wake_a: assert property ($rose(pwr_enable_i) |-> pump_output_oe_n_o)
        else $error("pump driven on power-up edge");
    rst_state_a: assert property (disable iff (1'b0) !nrst_i |=> pump_off_s ##0
        (!lock_indicator_out_o && !lock_indicator_out_oe_n_o)) else $error("bad reset state");
    pump_cause_a: assert property ($fell(pump_output_oe_n_o) |-> recent_cause_s)
        else $error("pump started without input edge");
    lock_cause_a: assert property ($changed(lock_indicator_out_o) |-> recent_cause_s)
        else $error("lock output moved without cause");
    lock_oe_cause_a: assert property ($changed(lock_indicator_out_oe_n_o) |-> recent_cause_s)
        else $error("lock enable moved without cause");
endmodule
bind pss_synth_front pss_synth_front_sva chk_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .word_latch_strobe_i(word_latch_strobe_i), .pwr_enable_i(pwr_enable_i),
    .ref_osc_input_i(ref_osc_input_i), .rf_prescaler_input_i(rf_prescaler_input_i),
    .pump_output_o(pump_output_o), .pump_output_oe_n_o(pump_output_oe_n_o),
    .lock_indicator_out_o(lock_indicator_out_o),
    .lock_indicator_out_oe_n_o(lock_indicator_out_oe_n_o));

//--- tb/pss_synth_front_test.sv
// Self-checking bench for the synthesizer front end.
module pss_synth_front_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk_i;
    logic nrst_i;
    logic pwr_enable_i;
    logic osc;
    logic rf;
    logic sclk;
    logic sdata;
    logic strobe;
    logic pump;
    logic pump_oe_n;
    logic lock;
    logic lock_oe_n;
    logic lock_q = 1'b0;
    int   miscompares = 0;
    int   total_checks = 0;
    int   cyc = 0;
    int   rises = 0;
    int   t_last = 0;
    int   t_gap = 0;
    int   base;
    pss_host_model host_u (.serial_clk_o(sclk), .serial_data_o(sdata),
        .word_latch_strobe_o(strobe));
    pss_synth_front dut_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .serial_clk_i(sclk),
        .serial_data_i(sdata), .word_latch_strobe_i(strobe), .pwr_enable_i(pwr_enable_i),
        .ref_osc_input_i(osc), .rf_prescaler_input_i(rf), .pump_output_o(pump),
        .pump_output_oe_n_o(pump_oe_n), .lock_indicator_out_o(lock),
        .lock_indicator_out_oe_n_o(lock_oe_n));
    // Pulse counting and spacing on the lock pin, in clock cycles.
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        lock_q <= lock;
        if (lock === 1'b1 && lock_q === 1'b0) begin
            rises <= rises + 1;
            t_gap <= cyc - t_last;
            t_last <= cyc;
        end
    end
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    // Edges are 4 clocks apart, 8 between rises, so the pin filter always accepts them.
    task automatic toggle(input bit use_rf, input int n);
        repeat (n) begin
            if (use_rf) begin
                rf = 1'b1;
            end else begin
                osc = 1'b1;
            end
            tick(4);
            if (use_rf) begin
                rf = 1'b0;
            end else begin
                osc = 1'b0;
            end
            tick(4);
        end
    endtask
    task automatic t_reset();
        check(pump_oe_n, 1'b1, "pump released after reset");
        check(lock_oe_n, 1'b0, "lock pin driven after reset");
        $display("test reset done");
    endtask
    task automatic t_lock_select();
        for (int s = 0; s < 4; s++) begin
            host_u.send_word({s[1:0], 13'h0001, 1'b0});
            tick(12);
            check(lock_oe_n, s == 3, "lock pin release per source");
        end
        // One reference edge with no feedback leaves the phase detector pumping up.
        toggle(1'b0, 1);
        tick(4);
        check(lock_oe_n, 1'b0, "analog lock drives while phases differ");
        check(lock, 1'b0, "analog lock pulls low");
        check(pump_oe_n, 1'b0, "pump drives while reference leads");
        check(pump, 1'b1, "pump sources while reference leads");
        $display("test lock select done");
    endtask
    task automatic t_ref_div();
        host_u.send_word({2'h0, 13'h0004, 1'b0});
        base = rises;
        tick(4);
        toggle(1'b0, 12);
        tick(12);
        check(rises - base, 3, "reference pulses for twelve edges");
        check(t_gap, 32, "reference pulse spacing");
        $display("test reference divider done");
    endtask
    task automatic t_fb_div();
        host_u.send_word({2'h1, 13'h0001, 1'b0});
        host_u.send_word({10'h002, 5'h01, 1'b1});
        base = rises;
        tick(4);
        toggle(1'b1, 195);
        tick(12);
        check(rises - base, 3, "feedback pulses for 195 edges");
        check(t_gap, 520, "feedback spacing for ratio 65");
        $display("test feedback divider done");
    endtask
    task automatic t_power_down();
        pwr_enable_i = 1'b0;
        #1;
        check(pump_oe_n, 1'b1, "pump released at once");
        check(pump, 1'b0, "pump level in power-down");
        base = rises;
        toggle(1'b1, 70);
        check(pump_oe_n, 1'b1, "pump stays released");
        check(rises - base, 0, "no feedback pulses while powered down");
        pwr_enable_i = 1'b1;
        tick(10);
        $display("test power-down done");
    endtask
    // A mid-run reset realigns both dividers, so matched edges give coincident pulses.
    task automatic t_dig_lock();
        nrst_i = 1'b0;
        tick(4);
        nrst_i = 1'b1;
        tick(4);
        host_u.send_word({2'h2, 13'h0001, 1'b0});
        host_u.send_word({10'h001, 5'h00, 1'b1});
        for (int k = 0; k < 4; k++) begin
            check(lock, 1'b0, "no digital lock before four matches");
            toggle(1'b1, 31);
            rf = 1'b1;
            osc = 1'b1;
            tick(4);
            rf = 1'b0;
            osc = 1'b0;
            tick(4);
        end
        tick(8);
        check(lock, 1'b1, "digital lock after four matches");
        check(lock_oe_n, 1'b0, "digital lock is push-pull");
        check(pump_oe_n, 1'b1, "pump idle while phases agree");
        $display("test digital lock done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        nrst_i = 1'b0;
        pwr_enable_i = 1'b1;
        osc = 1'b0;
        rf = 1'b0;
        tick(4);
        nrst_i = 1'b1;
        tick(4);
        t_reset();
        t_lock_select();
        t_ref_div();
        t_fb_div();
        t_power_down();
        t_dig_lock();
        end_sim();
    end
endmodule
